// file: ubie_endpoints.sv
// endpoint logic behind the usb device core: bulk out ep2, interrupt in ep3,
// default descriptors. assumes the core delivers decoded packets on clk_in.
`include "ubie_cfg.svh"
module ubie_endpoints #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678 // arbitrary value, like VENDOR_ID
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic high_speed_in,
  input wire logic ep2_start_in,
  input wire logic ep2_byte_valid_in,
  input wire logic [7:0] ep2_byte_in,
  input wire logic ep2_end_in,
  input wire logic tx_room_in,
  output ubie_pkg::ubie_hs_t ep2_hs_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic [15:0] tx_len_out,
  output logic tx_len_valid_out,
  output logic tx_frame_end_out,
  input wire logic ep3_token_in,
  input wire logic ep3_ack_in,
  input wire ubie_pkg::ubie_report_t report_in,
  output logic ep3_nak_out,
  output logic ep3_valid_out,
  output logic [7:0] ep3_data_out,
  output logic ep3_last_out,
  output logic ep3_pending_out,
  input wire logic desc_rd_in,
  input wire ubie_pkg::ubie_desc_sel_t desc_sel_in,
  input wire logic [4:0] desc_index_in,
  input wire logic remote_wake_in,
  input wire ubie_pkg::ubie_eeprom_t eeprom_in,
  output logic [7:0] desc_data_out,
  output logic desc_valid_out
);
  import ubie_pkg::*;

  // ----------------------------------------------------------------
  // bulk out endpoint 2
  // ----------------------------------------------------------------
  logic ep2_accept;
  logic ep2_in_pkt;
  logic [8:0] ep2_count;
  ubie_frame_state_t fstate;
  ubie_frame_state_t next_fstate;
  wire logic [8:0] max_payload = high_speed_in ? `UBIE_HS_MAX_PAYLOAD : `UBIE_FS_MAX_PAYLOAD;
  wire logic ep2_take = ep2_byte_valid_in && ep2_in_pkt && ep2_accept;
  wire logic ep2_short = ep2_count < max_payload;
  wire logic ep2_close = ep2_end_in && ep2_in_pkt && ep2_accept && ep2_short;

  // accept is decided once at packet start so a packet is never half taken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ep2_accept <= 1'b0;
      ep2_in_pkt <= 1'b0;
      ep2_count <= 9'h000;
    end else if (ce_in) begin
      if (ep2_start_in) begin
        ep2_accept <= tx_room_in;
        ep2_in_pkt <= 1'b1;
        ep2_count <= 9'h000;
      end else if (ep2_end_in) begin
        ep2_in_pkt <= 1'b0;
      end else if (ep2_take && ep2_count != 9'h1FF) begin
        ep2_count <= ep2_count + 9'h001;
      end
    end
  end

  // frame parser: length low, length high, then payload bytes
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      F_LEN_LO: if (ep2_take) next_fstate = F_LEN_HI;
      F_LEN_HI: if (ep2_take) next_fstate = F_DATA;
      F_DATA: next_fstate = F_DATA;
      default: next_fstate = F_LEN_LO;
    endcase
    if (ep2_close) begin
      next_fstate = F_LEN_LO;
    end
  end

  // handshake pulses one cycle after the packet end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fstate <= F_LEN_LO;
      ep2_hs_out <= '0;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_len_out <= 16'h0000;
      tx_len_valid_out <= 1'b0;
      tx_frame_end_out <= 1'b0;
    end else if (ce_in) begin
      fstate <= next_fstate;
      ep2_hs_out.ack <= ep2_end_in && ep2_in_pkt && ep2_accept;
      ep2_hs_out.nak <= ep2_end_in && ep2_in_pkt && !ep2_accept;
      tx_frame_end_out <= ep2_close;
      tx_valid_out <= ep2_take && fstate == F_DATA;
      tx_len_valid_out <= ep2_take && fstate == F_LEN_HI;
      if (ep2_take) begin
        tx_data_out <= ep2_byte_in;
      end
      if (ep2_take && fstate == F_LEN_LO) begin
        tx_len_out[7:0] <= ep2_byte_in;
      end
      if (ep2_take && fstate == F_LEN_HI) begin
        tx_len_out[15:8] <= ep2_byte_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt in endpoint 3
  // ----------------------------------------------------------------
  ubie_ep3_state_t estate;
  ubie_report_t prev_report;
  ubie_report_t snap;
  logic [2:0] ep3_idx;
  // reserved bytes never raise an interrupt on their own
  wire logic report_changed = report_in.network_status_byte != prev_report.network_status_byte
    || report_in.receive_status_byte != prev_report.receive_status_byte
    || report_in.receive_overflow_count_byte != prev_report.receive_overflow_count_byte
    || report_in.received_frame_count != prev_report.received_frame_count
    || report_in.transmitted_frame_count != prev_report.transmitted_frame_count;
  wire logic ep3_delivered = ep3_ack_in && estate == E_WAIT;
  wire logic next_pending = report_changed || (ep3_pending_out && !ep3_delivered);
  wire logic ep3_idle_poll = ep3_token_in && estate == E_IDLE;
  wire logic [7:0] snap_byte = snap[{~ep3_idx, 3'b000} +: 8];

  // pending flag: a change in the ack cycle keeps it set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_report <= '0;
      ep3_pending_out <= 1'b0;
    end else if (ce_in) begin
      prev_report <= report_in;
      ep3_pending_out <= next_pending;
    end
  end

  // report sender; a repeat poll before the ack resends the same snapshot
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      estate <= E_IDLE;
      snap <= '0;
      ep3_idx <= 3'h0;
      ep3_nak_out <= 1'b0;
      ep3_valid_out <= 1'b0;
      ep3_data_out <= 8'h00;
      ep3_last_out <= 1'b0;
    end else if (ce_in) begin
      ep3_nak_out <= ep3_idle_poll && !ep3_pending_out;
      ep3_valid_out <= estate == E_SEND;
      ep3_last_out <= estate == E_SEND && ep3_idx == `UBIE_REPORT_LAST;
      ep3_data_out <= estate == E_SEND ? snap_byte : 8'h00;
      case (estate)
        E_IDLE: begin
          if (ep3_idle_poll && ep3_pending_out) begin
            snap <= report_in;
            ep3_idx <= 3'h0;
            estate <= E_SEND;
          end
        end
        E_SEND: begin
          ep3_idx <= ep3_idx + 3'h1;
          if (ep3_idx == `UBIE_REPORT_LAST) begin
            estate <= E_WAIT;
          end
        end
        E_WAIT: begin
          if (ep3_ack_in) begin
            estate <= E_IDLE;
          end else if (ep3_token_in) begin
            ep3_idx <= 3'h0;
            estate <= E_SEND;
          end
        end
        default: estate <= E_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // descriptor rom
  // ----------------------------------------------------------------
  wire logic [15:0] usb_bcd = `UBIE_USB_BCD;
  wire logic [15:0] dev_rel = `UBIE_DEV_RELEASE;
  wire logic [15:0] total_len = `UBIE_TOTAL_LEN;
  wire logic [15:0] vendor = eeprom_in.valid ? eeprom_in.vendor_id : VENDOR_ID;
  wire logic [15:0] ep1_mps = high_speed_in ? `UBIE_EP1_MPS_HS : `UBIE_EP1_MPS_FS;
  wire logic [7:0] attr = `UBIE_ATTR_BASE | (remote_wake_in ? `UBIE_ATTR_WAKE : 8'h00);
  wire logic [7:0] power = eeprom_in.valid ? eeprom_in.max_power : `UBIE_MAX_POWER;
  wire logic [7:0] ep1_ival = eeprom_in.valid ? eeprom_in.ep1_interval : `UBIE_EP1_INTERVAL;
  logic [7:0] desc_byte;

  // unlisted offsets, class codes and string indices of zero read as 00
  always_comb begin
    desc_byte = 8'h00;
    case (desc_sel_in)
      DESC_DEVICE: begin
        case (desc_index_in)
          5'h00: desc_byte = `UBIE_DEV_LEN;
          5'h01: desc_byte = `UBIE_TYPE_DEVICE;
          5'h02: desc_byte = usb_bcd[7:0];
          5'h03: desc_byte = usb_bcd[15:8];
          5'h07: desc_byte = `UBIE_EP0_MPS;
          5'h08: desc_byte = vendor[7:0];
          5'h09: desc_byte = vendor[15:8];
          5'h0A: desc_byte = PRODUCT_ID[7:0];
          5'h0B: desc_byte = PRODUCT_ID[15:8];
          5'h0C: desc_byte = dev_rel[7:0];
          5'h0D: desc_byte = dev_rel[15:8];
          5'h0E: desc_byte = `UBIE_STR_MANUF;
          5'h0F: desc_byte = `UBIE_STR_PRODUCT;
          5'h10: desc_byte = `UBIE_STR_SERIAL;
          5'h11: desc_byte = `UBIE_NUM_CONFIGS;
          default: desc_byte = 8'h00;
        endcase
      end
      DESC_CONFIG: begin
        case (desc_index_in)
          5'h00: desc_byte = `UBIE_CFG_LEN;
          5'h01: desc_byte = `UBIE_TYPE_CONFIG;
          5'h02: desc_byte = total_len[7:0];
          5'h03: desc_byte = total_len[15:8];
          5'h04: desc_byte = `UBIE_NUM_IFACES;
          5'h05: desc_byte = `UBIE_CFG_VALUE;
          5'h07: desc_byte = attr;
          5'h08: desc_byte = power;
          default: desc_byte = 8'h00;
        endcase
      end
      DESC_IFACE: begin
        case (desc_index_in)
          5'h00: desc_byte = `UBIE_IF_LEN;
          5'h01: desc_byte = `UBIE_TYPE_IFACE;
          5'h04: desc_byte = `UBIE_NUM_EPS;
          default: desc_byte = 8'h00;
        endcase
      end
      DESC_EP1: begin
        case (desc_index_in)
          5'h00: desc_byte = `UBIE_EP_LEN;
          5'h01: desc_byte = `UBIE_TYPE_EP;
          5'h02: desc_byte = `UBIE_EP1_ADDR;
          5'h03: desc_byte = `UBIE_EP_BULK;
          5'h04: desc_byte = ep1_mps[7:0];
          5'h05: desc_byte = ep1_mps[15:8];
          5'h06: desc_byte = ep1_ival;
          default: desc_byte = 8'h00;
        endcase
      end
      default: desc_byte = 8'h00;
    endcase
  end

  // registered read port, one cycle latency
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      desc_data_out <= 8'h00;
      desc_valid_out <= 1'b0;
    end else if (ce_in) begin
      desc_valid_out <= desc_rd_in;
      if (desc_rd_in) begin
        desc_data_out <= desc_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in iff ce_in); endclocking
  default disable iff (rst_in);
  sequence s_poll_pending;
    ep3_token_in && estate == E_IDLE && ep3_pending_out;
  endsequence
  sequence s_report_burst;
    (ep3_valid_out && !ep3_nak_out)[*8] ##1 !ep3_valid_out;
  endsequence
  a_ep2_ack_room: assert property (ep2_end_in && ep2_in_pkt && ep2_accept |=> ep2_hs_out.ack && !ep2_hs_out.nak)
    else $error("ep2 packet with room not acked");
  // any refused packet, whatever its length, ends in nak and leaves the frame alone
  a_ep2_nak_full: assert property (ep2_end_in && ep2_in_pkt && !ep2_accept
    |=> ep2_hs_out.nak && !ep2_hs_out.ack && !tx_frame_end_out)
    else $error("ep2 packet without room not nakked");
  a_short_closes: assert property (ep2_close |=> tx_frame_end_out ##0 fstate == F_LEN_LO)
    else $error("short ep2 packet did not close frame");
  a_len_high: assert property (ep2_take && fstate == F_LEN_HI
    |=> tx_len_valid_out && !tx_valid_out && tx_len_out[15:8] == $past(ep2_byte_in))
    else $error("frame length high byte misplaced");
  a_poll_nak: assert property (ep3_token_in && estate == E_IDLE && !ep3_pending_out
    |=> ep3_nak_out && !ep3_valid_out)
    else $error("idle ep3 poll not nakked");
  // the sender state moves on the token edge, the first byte shows one edge later
  a_report_run: assert property (s_poll_pending |=> ##1 s_report_burst)
    else $error("pending ep3 poll did not send eight bytes");
  a_report_order: assert property (s_poll_pending |=> ##1
    ep3_data_out == $past(report_in.network_status_byte, 2)
    ##6 ep3_data_out == $past(report_in.transmitted_frame_count, 8))
    else $error("ep3 report byte order wrong");
  a_dev_header: assert property (desc_rd_in && desc_sel_in == DESC_DEVICE && desc_index_in == 5'h00
    |=> desc_valid_out && desc_data_out == `UBIE_DEV_LEN)
    else $error("device descriptor length wrong");
  a_wake_attr: assert property (desc_rd_in && desc_sel_in == DESC_CONFIG && desc_index_in == 5'h07
    |=> desc_data_out == ($past(remote_wake_in) ? 8'hA0 : 8'h80))
    else $error("configuration attributes wrong");
  a_ep1_size: assert property (desc_rd_in && desc_sel_in == DESC_EP1 && desc_index_in == 5'h05
    |=> desc_data_out == ($past(high_speed_in) ? 8'h02 : 8'h00))
    else $error("ep1 max packet size wrong");
  a_pending_hold: assert property (ep3_pending_out && !ep3_delivered |=> ep3_pending_out)
    else $error("ep3 pending lost without ack");
endmodule : ubie_endpoints

// file: ubie_cfg.svh
// constants for the bulk/interrupt endpoint block: payload sizes, report size,
// descriptor field values; included by the endpoint module only
`ifndef UBIE_CFG_SVH
`define UBIE_CFG_SVH
// bulk payload limits per bus speed, last interrupt report byte index
`define UBIE_FS_MAX_PAYLOAD 9'h040
`define UBIE_HS_MAX_PAYLOAD 9'h100
`define UBIE_REPORT_LAST 3'h7
// device descriptor
`define UBIE_DEV_LEN 8'h12
`define UBIE_TYPE_DEVICE 8'h01
`define UBIE_USB_BCD 16'h0200
`define UBIE_EP0_MPS 8'h08
`define UBIE_DEV_RELEASE 16'h0101
`define UBIE_STR_MANUF 8'h01
`define UBIE_STR_PRODUCT 8'h02
`define UBIE_STR_SERIAL 8'h03
`define UBIE_NUM_CONFIGS 8'h01
// configuration descriptor
`define UBIE_CFG_LEN 8'h09
`define UBIE_TYPE_CONFIG 8'h02
`define UBIE_TOTAL_LEN 16'h0027
`define UBIE_NUM_IFACES 8'h01
`define UBIE_CFG_VALUE 8'h01
`define UBIE_ATTR_BASE 8'h80
`define UBIE_ATTR_WAKE 8'h20
`define UBIE_MAX_POWER 8'h3C
// interface descriptor
`define UBIE_IF_LEN 8'h09
`define UBIE_TYPE_IFACE 8'h04
`define UBIE_NUM_EPS 8'h03
// endpoint 1 descriptor
`define UBIE_EP_LEN 8'h07
`define UBIE_TYPE_EP 8'h05
`define UBIE_EP1_ADDR 8'h81
`define UBIE_EP_BULK 8'h02
`define UBIE_EP1_MPS_FS 16'h0040
`define UBIE_EP1_MPS_HS 16'h0200
`define UBIE_EP1_INTERVAL 8'h00
`endif

// file: ubie_pkg.sv
// types shared by the endpoint block: report layout, strap bundle, states
// assumes nothing beyond a SystemVerilog compiler
package ubie_pkg;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // byte 0 sits in the top bits so the report reads in wire order
  typedef struct packed {
    logic [7:0] network_status_byte;
    logic [7:0] reserved_report_byte_one;
    logic [7:0] reserved_report_byte_two;
    logic [7:0] receive_status_byte;
    logic [7:0] receive_overflow_count_byte;
    logic [7:0] received_frame_count;
    logic [7:0] transmitted_frame_count;
    logic [7:0] reserved_report_byte_seven;
  } ubie_report_t;
  typedef struct packed {
    logic valid;
    logic [15:0] vendor_id;
    logic [7:0] max_power;
    logic [7:0] ep1_interval;
  } ubie_eeprom_t;
  typedef struct packed {
    logic ack;
    logic nak;
  } ubie_hs_t;
  // ----------------------------------------------------------------
  // selectors and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DESC_DEVICE = 2'h0,
    DESC_CONFIG = 2'h1,
    DESC_IFACE = 2'h2,
    DESC_EP1 = 2'h3
  } ubie_desc_sel_t;
  typedef enum logic [2:0] {
    F_LEN_LO = 3'h1,
    F_LEN_HI = 3'h2,
    F_DATA = 3'h4
  } ubie_frame_state_t;
  typedef enum logic [2:0] {
    E_IDLE = 3'h1,
    E_SEND = 3'h2,
    E_WAIT = 3'h4
  } ubie_ep3_state_t;
endpackage : ubie_pkg

// file: ubie_host_model.sv
// host controller model: bulk out packets on ep2, interrupt polls on ep3
// assumes the endpoint block samples its inputs on the rising edge of clk_in
module ubie_host_model (
  input wire logic clk_in,
  input wire logic ep3_last_in,
  input wire logic ep3_nak_in,
  output logic ep2_start_out,
  output logic ep2_byte_valid_out,
  output logic [7:0] ep2_byte_out,
  output logic ep2_end_out,
  output logic ep3_token_out,
  output logic ep3_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    ep2_start_out = 1'b0;
    ep2_byte_valid_out = 1'b0;
    ep2_byte_out = 8'h00;
    ep2_end_out = 1'b0;
    ep3_token_out = 1'b0;
    ep3_ack_out = 1'b0;
  end
  // ----------------------------------------------------------------
  // bulk out packet: start, n bytes, end; with with_hdr set the first two carry the length
  // ----------------------------------------------------------------
  task automatic send_pkt(input int n, input logic [15:0] hdr, input bit with_hdr);
    int k;
    @(negedge clk_in) ep2_start_out = 1'b1;
    @(negedge clk_in) ep2_start_out = 1'b0;
    for (k = 0; k < n; k++) begin
      ep2_byte_out = (with_hdr && k < 2) ? hdr[8*k +: 8] : k[7:0];
      ep2_byte_valid_out = 1'b1;
      @(negedge clk_in);
    end
    // released data line shows the inverse so stale bytes cannot pass
    ep2_byte_valid_out = 1'b0;
    ep2_byte_out = ~ep2_byte_out;
    ep2_end_out = 1'b1;
    @(negedge clk_in) ep2_end_out = 1'b0;
  endtask : send_pkt
  // ----------------------------------------------------------------
  // interrupt poll: token, wait for report or nak, ack after last byte
  // ----------------------------------------------------------------
  task automatic poll(input bit do_ack, output bit got);
    int w;
    @(negedge clk_in) ep3_token_out = 1'b1;
    @(negedge clk_in) ep3_token_out = 1'b0;
    w = 0;
    while (w < 12 && ep3_last_in !== 1'b1 && ep3_nak_in !== 1'b1) begin
      @(negedge clk_in);
      w++;
    end
    got = (ep3_last_in === 1'b1);
    // ack no earlier than the cycle after the last byte
    if (got && do_ack) begin
      @(negedge clk_in) ep3_ack_out = 1'b1;
      @(negedge clk_in) ep3_ack_out = 1'b0;
    end
  endtask : poll
endmodule : ubie_host_model

// file: ubie_endpoints_tb.sv
// self-checking bench for the endpoint block with a host model on ep2/ep3
// assumes the block's default timing: registered one-cycle answers
module ubie_endpoints_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ubie_pkg::*;
  localparam logic [15:0] DEF_VID = 16'h1234; // arbitrary value
  localparam logic [15:0] DEF_PID = 16'h5678; // arbitrary value
  localparam logic [15:0] EE_VID = 16'hC0DE; // arbitrary value
  logic clk_in, rst_in, ce_in, high_speed_in, tx_room_in, desc_rd_in, remote_wake_in;
  logic ep2_start, ep2_valid, ep2_end, ep3_token, ep3_ack, got;
  logic [7:0] ep2_byte, tx_data, ep3_data, desc_data;
  logic [15:0] tx_len, len_seen;
  logic tx_valid, tx_len_valid, tx_fend, ep3_nak, ep3_valid, ep3_last, ep3_pend, desc_valid;
  logic [4:0] desc_index_in;
  ubie_hs_t ep2_hs;
  ubie_report_t report_in;
  ubie_desc_sel_t desc_sel_in;
  ubie_eeprom_t eeprom_in;
  int failures, num_checks, n_ack, n_nak, n_fend, n_enak, n_last;
  logic [7:0] txq[$];
  logic [7:0] ep3q[$];
  // ----------------------------------------------------------------
  // design, host model, clock
  // ----------------------------------------------------------------
  ubie_endpoints #(.VENDOR_ID(DEF_VID), .PRODUCT_ID(DEF_PID)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .high_speed_in(high_speed_in),
    .ep2_start_in(ep2_start), .ep2_byte_valid_in(ep2_valid), .ep2_byte_in(ep2_byte),
    .ep2_end_in(ep2_end), .tx_room_in(tx_room_in), .ep2_hs_out(ep2_hs), .tx_valid_out(tx_valid),
    .tx_data_out(tx_data), .tx_len_out(tx_len), .tx_len_valid_out(tx_len_valid),
    .tx_frame_end_out(tx_fend), .ep3_token_in(ep3_token), .ep3_ack_in(ep3_ack),
    .report_in(report_in), .ep3_nak_out(ep3_nak), .ep3_valid_out(ep3_valid),
    .ep3_data_out(ep3_data), .ep3_last_out(ep3_last), .ep3_pending_out(ep3_pend),
    .desc_rd_in(desc_rd_in), .desc_sel_in(desc_sel_in), .desc_index_in(desc_index_in),
    .remote_wake_in(remote_wake_in), .eeprom_in(eeprom_in), .desc_data_out(desc_data),
    .desc_valid_out(desc_valid));
  ubie_host_model u_host (
    .clk_in(clk_in), .ep3_last_in(ep3_last), .ep3_nak_in(ep3_nak), .ep2_start_out(ep2_start),
    .ep2_byte_valid_out(ep2_valid), .ep2_byte_out(ep2_byte), .ep2_end_out(ep2_end),
    .ep3_token_out(ep3_token), .ep3_ack_out(ep3_ack));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // one-cycle pulses are counted here so no scenario can miss them
  always @(posedge clk_in) begin
    if (ep2_hs.ack === 1'b1) n_ack++;
    if (ep2_hs.nak === 1'b1) n_nak++;
    if (tx_fend === 1'b1) n_fend++;
    if (ep3_nak === 1'b1) n_enak++;
    if (ep3_last === 1'b1) n_last++;
    if (tx_valid === 1'b1) txq.push_back(tx_data);
    if (tx_len_valid === 1'b1) len_seen = tx_len;
    if (ep3_valid === 1'b1) ep3q.push_back(ep3_data);
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic clr();
    n_ack = 0; n_nak = 0; n_fend = 0; n_enak = 0; n_last = 0;
    txq.delete();
    ep3q.delete();
  endtask : clr
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wait_n
  // expected descriptor byte; zero padding covers out-of-range offsets
  function automatic logic [7:0] exp_desc(input int sel, input int idx, input bit hs, input bit wk, input bit ee);
    logic [255:0] v;
    logic [15:0] vid;
    logic [7:0] pw, iv;
    vid = ee ? EE_VID : DEF_VID;
    pw = ee ? 8'h32 : 8'h3C;
    iv = ee ? 8'h0A : 8'h00;
    case (sel)
      0: v = {8'h12, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h08, vid[7:0], vid[15:8],
              DEF_PID[7:0], DEF_PID[15:8], 8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h01, 112'h0};
      1: v = {8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, (wk ? 8'hA0 : 8'h80), pw, 184'h0};
      2: v = {8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 184'h0};
      default: v = {8'h07, 8'h05, 8'h81, 8'h02, (hs ? 16'h0002 : 16'h4000), iv, 200'h0};
    endcase
    return v[255-8*idx -: 8];
  endfunction : exp_desc
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(16'({ep3_pend, ep3_valid, ep3_nak, tx_valid, tx_fend, desc_valid, ep2_hs}), 16'h0000);
  endtask : t_reset
  // low enable freezes the read port; the held read lands once enabled
  task automatic t_freeze();
    desc_sel_in = DESC_DEVICE;
    desc_index_in = 5'h00;
    desc_rd_in = 1'b1;
    ce_in = 1'b0;
    wait_n(2);
    check({desc_valid, 7'h00, desc_data}, 16'h0000);
    ce_in = 1'b1;
    @(negedge clk_in);
    desc_rd_in = 1'b0;
    check({desc_valid, 7'h00, desc_data}, 16'h8012);
  endtask : t_freeze
  task automatic t_short_frame();
    clr();
    u_host.send_pkt(3, 16'h0005, 1'b1);
    wait_n(3);
    check(16'(n_ack), 16'h0001);
    check(16'(n_fend), 16'h0001);
    check(len_seen, 16'h0005);
    check(16'({txq.size(), txq[0]}), 16'h0102);
  endtask : t_short_frame
  // a refused packet must leave the parser waiting for a length byte
  task automatic t_full_nak();
    clr();
    tx_room_in = 1'b0;
    u_host.send_pkt(2, 16'h0102, 1'b1);
    wait_n(3);
    tx_room_in = 1'b1;
    check(16'({4'(n_nak), 4'(n_ack), 4'(n_fend), 4'(txq.size())}), 16'h1000);
  endtask : t_full_nak
  // full packet keeps the frame open; zero or one-short packet closes it
  task automatic t_max_packets();
    int s, mp, sec, tot;
    for (s = 0; s < 2; s++) begin
      high_speed_in = s[0];
      mp = s ? 256 : 64;
      sec = s ? mp - 1 : 0;
      tot = mp - 2 + sec;
      clr();
      u_host.send_pkt(mp, tot[15:0], 1'b1);
      wait_n(3);
      check(16'({4'(n_ack), 4'(n_fend)}), 16'h0010);
      check(len_seen, tot[15:0]);
      u_host.send_pkt(sec, 16'h0000, 1'b0);
      wait_n(3);
      check(16'({4'(n_ack), 4'(n_fend)}), 16'h0021);
      check(16'(txq.size()), tot[15:0]);
    end
    high_speed_in = 1'b0;
  endtask : t_max_packets
  task automatic t_ep3();
    logic [63:0] rep;
    int i;
    clr();
    u_host.poll(1'b1, got);
    wait_n(2);
    check(16'({4'(got), 4'(n_enak), 4'(ep3q.size())}), 16'h0010);
    report_in.reserved_report_byte_one = 8'h5A;
    wait_n(3);
    check(16'(ep3_pend), 16'h0000);
    rep = {8'h11, 8'h5A, 8'h00, 8'h44, 8'h55, 8'h66, 8'h77, 8'h99};
    report_in = rep;
    wait_n(3);
    check(16'(ep3_pend), 16'h0001);
    clr();
    u_host.poll(1'b1, got);
    wait_n(3);
    check(16'({4'(got), 4'(n_enak), 4'(n_last)}), 16'h0101);
    check(16'(ep3q.size()), 16'h0008);
    for (i = 0; i < 8; i++) begin
      check(16'(ep3q[i]), 16'(rep[63-8*i -: 8]));
    end
    check(16'(ep3_pend), 16'h0000);
  endtask : t_ep3
  // back-to-back reads over every descriptor and past its end
  task automatic t_desc(input bit hs, input bit wk, input bit ee);
    int sel, idx;
    high_speed_in = hs;
    remote_wake_in = wk;
    eeprom_in = '{valid: ee, vendor_id: EE_VID, max_power: 8'h32, ep1_interval: 8'h0A};
    for (sel = 0; sel < 4; sel++) begin
      for (idx = 0; idx < 20; idx++) begin
        desc_sel_in = ubie_desc_sel_t'(sel[1:0]);
        desc_index_in = idx[4:0];
        desc_rd_in = 1'b1;
        @(negedge clk_in);
        check({desc_valid, 7'h00, desc_data}, {8'h80, exp_desc(sel, idx, hs, wk, ee)});
      end
    end
    desc_rd_in = 1'b0;
    high_speed_in = 1'b0;
  endtask : t_desc
  // ----------------------------------------------------------------
  // verdict, watchdog, main sequence
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // whole run needs well under 2000 cycles; hang cut at ten times that
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    report_and_stop();
  end
  initial begin
    failures = 0; num_checks = 0; len_seen = 16'h0000;
    rst_in = 1'b1; ce_in = 1'b1; high_speed_in = 1'b0; tx_room_in = 1'b1; desc_rd_in = 1'b0;
    remote_wake_in = 1'b0; desc_sel_in = DESC_DEVICE; desc_index_in = 5'h00;
    report_in = '0;
    eeprom_in = '0;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'b0;
    t_reset();
    t_freeze();
    t_short_frame();
    t_full_nak();
    t_max_packets();
    t_ep3();
    t_desc(1'b0, 1'b0, 1'b0);
    t_desc(1'b1, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule : ubie_endpoints_tb
